// ===== logic/sbrg_defines.svh
`ifndef SBRG_DEFINES_SVH
`define SBRG_DEFINES_SVH
// ============================================================
// Register map.
`define SBRG_OFF_CTRL 12'h000
`define SBRG_OFF_DIV_LO 12'h004
`define SBRG_OFF_DIV_HI 12'h008
`define SBRG_OFF_STATUS 12'h00c
`define SBRG_OFF_AUTO 12'h010
// ============================================================
// Control field positions.
`define SBRG_CTRL_SYNC 0
`define SBRG_CTRL_HS 1
`define SBRG_CTRL_WIDE 2
`define SBRG_CTRL_AUTO_EN 3
// ============================================================
// Reset values.
`define SBRG_CTRL_RST 4'h0
`define SBRG_DIV_RST 8'h00
// ============================================================
// Base-clock prescale terminal counts, one less than the clocks per divisor step.
`define SBRG_PRE_64 6'h3f
`define SBRG_PRE_16 6'h0f
`define SBRG_PRE_4 6'h03
`endif

// ===== logic/sbrg_pkg.sv
`default_nettype none
package sbrg_pkg;
  typedef enum logic [1:0] {
    SBRG_DIV64 = 2'b00,
    SBRG_DIV16 = 2'b01,
    SBRG_DIV4 = 2'b10
  } sbrg_mult_t;
endpackage
`default_nettype wire

// ===== logic/sbrg_top.sv
// Contract
// - Timer serves async and sync; 8-bit after reset, 16-bit when wide set.
// - Divisor low byte sets the free-running timer period, with the high byte added only when wide is set.
// - Async multiplier chosen by high-speed select and width select together.
// - Sync mode ignores high-speed select.
// - Async, narrow, low speed: rate is clock over 64 times divisor plus one.
// - Sync mode: rate is clock over 4 times divisor plus one, any width.
// - A divisor write clears the timer so the new rate applies at once.
// - Auto-baud logic may load the divisor besides software writes.
//
// Our own choices: the register offsets and the APB slave port.
`include "sbrg_defines.svh"
`default_nettype none
module sbrg_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic auto_load,
  input wire logic [15:0] auto_divisor,
  output logic baud_tick,
  output logic sample_tick,
  output logic sync_mode,
  output logic wide_divider_select,
  output logic high_speed_select
);
  import sbrg_pkg::*;

  // ==========================================================
  // Register bus.
  logic [3:0] ctrl_reg, ctrl_next;
  logic [7:0] div_lo_reg, div_lo_next, div_hi_reg, div_hi_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic restart;
  logic setup, access, wr_hit;
  logic [5:0] pre_reg, pre_next;
  logic [15:0] cnt_reg, cnt_next;
  logic tick_reg, tick_next, stick_reg, stick_next;

  // Reads are decoded in the setup cycle so the data stands in the access
  // cycle. Writes land only at the edge that completes the access, so a
  // master that stalls never sees a write take effect early.
  assign setup = psel && !penable;
  assign access = psel && penable && pready_reg;
  assign wr_hit = access && pwrite && pstrb[0];

  always_comb begin
    ctrl_next = ctrl_reg;
    div_lo_next = div_lo_reg;
    div_hi_next = div_hi_reg;
    prdata_next = prdata_reg;
    pready_next = setup;
    pslverr_next = 1'b0;
    restart = 1'b0;
    if (setup) begin
      prdata_next = 32'h0000_0000;
      unique case (paddr)
        `SBRG_OFF_CTRL: begin
          prdata_next = {28'h0000000, ctrl_reg};
        end
        `SBRG_OFF_DIV_LO: begin
          prdata_next = {24'h000000, div_lo_reg};
        end
        `SBRG_OFF_DIV_HI: begin
          prdata_next = {24'h000000, div_hi_reg};
        end
        `SBRG_OFF_STATUS: begin
          prdata_next = {16'h0000, cnt_reg};
        end
        `SBRG_OFF_AUTO: begin
          prdata_next = {16'h0000, div_hi_reg, div_lo_reg};
        end
        default: begin
          pslverr_next = 1'b1;
        end
      endcase
    end
    // Status and auto words are read-only; writes to them are dropped.
    if (wr_hit) begin
      unique case (paddr)
        `SBRG_OFF_CTRL: begin
          ctrl_next = pwdata[3:0];
        end
        `SBRG_OFF_DIV_LO: begin
          div_lo_next = pwdata[7:0];
          restart = 1'b1;
        end
        `SBRG_OFF_DIV_HI: begin
          div_hi_next = pwdata[7:0];
          restart = 1'b1;
        end
        default: begin
        end
      endcase
    end
    // Auto-baud load only applies when no software write is in flight.
    if (auto_load && ctrl_reg[`SBRG_CTRL_AUTO_EN] && !wr_hit) begin
      div_lo_next = auto_divisor[7:0];
      div_hi_next = auto_divisor[15:8];
      restart = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SBRG_CTRL_RST;
      div_lo_reg <= `SBRG_DIV_RST;
      div_hi_reg <= `SBRG_DIV_RST;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      div_lo_reg <= div_lo_next;
      div_hi_reg <= div_hi_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ==========================================================
  // Multiplier selection.
  function automatic sbrg_mult_t sbrg_pick(input logic [3:0] c);
    if (c[`SBRG_CTRL_SYNC]) begin
      return SBRG_DIV4;
    end else if (c[`SBRG_CTRL_HS] && c[`SBRG_CTRL_WIDE]) begin
      return SBRG_DIV4;
    end else if (c[`SBRG_CTRL_HS] || c[`SBRG_CTRL_WIDE]) begin
      return SBRG_DIV16;
    end else begin
      return SBRG_DIV64;
    end
  endfunction

  function automatic logic [5:0] sbrg_pre(input sbrg_mult_t m);
    unique case (m)
      SBRG_DIV64: return `SBRG_PRE_64;
      SBRG_DIV16: return `SBRG_PRE_16;
      SBRG_DIV4: return `SBRG_PRE_4;
      default: return `SBRG_PRE_64;
    endcase
  endfunction

  sbrg_mult_t mult;
  logic [15:0] reload;
  assign mult = sbrg_pick(ctrl_reg);
  assign reload = ctrl_reg[`SBRG_CTRL_WIDE] ? {div_hi_reg, div_lo_reg}
                                             : {8'h00, div_lo_reg};

  // ==========================================================
  // Baud divider timer: prescaler then divisor down-counter.
  always_comb begin
    pre_next = pre_reg;
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    stick_next = 1'b0;
    if (restart) begin
      pre_next = 6'h00;
      cnt_next = 16'h0000;
    end else if (pre_reg >= sbrg_pre(mult)) begin
      pre_next = 6'h00;
      stick_next = 1'b1;
      if (cnt_reg == 16'h0000) begin
        cnt_next = reload;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - 16'h0001;
      end
    end else begin
      pre_next = pre_reg + 6'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 6'h00;
      cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
      stick_reg <= 1'b0;
      sync_mode <= 1'b0;
      wide_divider_select <= 1'b0;
      high_speed_select <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
      stick_reg <= stick_next;
      sync_mode <= ctrl_reg[`SBRG_CTRL_SYNC];
      wide_divider_select <= ctrl_reg[`SBRG_CTRL_WIDE];
      high_speed_select <= ctrl_reg[`SBRG_CTRL_HS];
    end
  end

  assign baud_tick = tick_reg;
  assign sample_tick = stick_reg;

  // ==========================================================
  // Checks.
  sequence s_div_write;
    psel && penable && pready && pwrite && pstrb[0] &&
    (paddr == `SBRG_OFF_DIV_LO || paddr == `SBRG_OFF_DIV_HI);
  endsequence

  sequence s_ctrl_setup;
    psel && !penable && paddr == `SBRG_OFF_CTRL;
  endsequence

  sequence s_unmapped_setup;
    psel && !penable && paddr != `SBRG_OFF_CTRL &&
    paddr != `SBRG_OFF_DIV_LO && paddr != `SBRG_OFF_DIV_HI &&
    paddr != `SBRG_OFF_STATUS && paddr != `SBRG_OFF_AUTO;
  endsequence

  a_ctrl_read_data: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ctrl_setup |=> prdata == {28'h0000000, $past(ctrl_reg)})
    else $error("control read data wrong in access cycle");

  a_no_setup_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ctrl_setup ##0 pwrite |=> ctrl_reg == $past(ctrl_reg))
    else $error("control written in setup cycle");

  a_ctrl_write_lands: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && pwrite && pstrb[0] &&
     paddr == `SBRG_OFF_CTRL) |=> ctrl_reg == $past(pwdata[3:0]))
    else $error("control write did not land");

  a_err_unmapped: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_unmapped_setup |=> pslverr && pready)
    else $error("unmapped address gave no error");

  a_tick_on_sample: assert property (
    @(posedge pclk) disable iff (!presetn)
    baud_tick |-> sample_tick)
    else $error("bit tick outside a prescale step");

  a_ready_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready stood longer than one cycle");

  a_write_clears_timer: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_div_write |=> (cnt_reg == 16'h0000 && pre_reg == 6'h00))
    else $error("divisor write did not clear the timer");

  a_narrow_reload: assert property (
    @(posedge pclk) disable iff (!presetn)
    (tick_reg && !$past(restart) && !$past(ctrl_reg[`SBRG_CTRL_WIDE]))
    |-> cnt_reg[15:8] == 8'h00)
    else $error("narrow mode loaded high byte");

  a_sync_ignores_hs: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctrl_reg[`SBRG_CTRL_SYNC] |-> mult == SBRG_DIV4)
    else $error("sync mode did not use divide by four");

  a_slow_mult: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ctrl_reg[2:0] == 3'b000) |-> sbrg_pre(mult) == 6'h3f)
    else $error("slow async mode not divide by 64");

  a_mid_mult: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!ctrl_reg[0] && (ctrl_reg[1] ^ ctrl_reg[2]))
    |-> sbrg_pre(mult) == 6'h0f)
    else $error("single select not divide by 16");

  a_fast_mult: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ctrl_reg[2:0] == 3'b110) |-> sbrg_pre(mult) == 6'h03)
    else $error("both selects not divide by 4");

  a_tick_reload: assert property (
    @(posedge pclk) disable iff (!presetn)
    (tick_reg && !$past(restart)) |-> cnt_reg == $past(reload))
    else $error("timer did not reload from divisor");

  a_sample_spacing: assert property (
    @(posedge pclk) disable iff (!presetn)
    (stick_reg && ctrl_reg[0] && $stable(ctrl_reg) && !restart)
    |=> !stick_reg[*3])
    else $error("sync sample ticks closer than four clocks");

  a_bus_answer: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("bus did not answer after setup");
endmodule // sbrg_top
`default_nettype wire

// ===== testbench/sbrg_shift_model.sv
`default_nettype none
// ============================================================
// Shift-side stand-in: measures clocks between bit ticks.
module sbrg_shift_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic baud_tick,
  output logic [19:0] period
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [19:0] cnt_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      period <= '0;
    end else if (baud_tick) begin
      period <= cnt_reg + 20'h1;
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 20'h1;
    end
  end
endmodule // sbrg_shift_model
`default_nettype wire

// ===== testbench/tb_serial_baud_rate_generator.sv
`default_nettype none
module tb_serial_baud_rate_generator;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic auto_load = 0, pready, pslverr, slv, baud_tick, sample_tick;
  logic sync_mode, wide_divider_select, high_speed_select;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [15:0] auto_divisor = '0;
  logic [19:0] period;
  logic [7:0] lo;
  logic [3:0] pstrb = 4'hf;
  integer fail_count = 0, n_tests = 0, seed = 32'hb2ed59ef;
  sbrg_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .auto_load(auto_load), .auto_divisor(auto_divisor),
    .baud_tick(baud_tick), .sample_tick(sample_tick),
    .sync_mode(sync_mode), .wide_divider_select(wide_divider_select),
    .high_speed_select(high_speed_select));
  sbrg_shift_model model (.pclk(pclk), .presetn(presetn),
    .baud_tick(baud_tick), .period(period));
  always #10 pclk = ~pclk;
  // ============================================================
  // Helpers.
  function automatic logic [19:0] exp_period(input logic [2:0] c,
      input logic [7:0] h, input logic [7:0] l);
    logic [19:0] m;
    logic [19:0] n;
    n = c[2] ? {4'h0, h, l} : {12'h0, l};
    if (c[0] || (c[1] && c[2])) m = 20'h4;
    else if (c[1] || c[2]) m = 20'h10;
    else m = 20'h40;
    return m * (n + 20'h1);
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    chk("pready", 32'h1, {31'h0, pready});
    if (pready !== 1'b1) end_of_test();
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_tick(input int bound);
    int i;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (baud_tick !== 1'b1 && i < bound);
    chk("tick_in_time", 32'h1, {31'h0, baud_tick});
    if (baud_tick !== 1'b1) end_of_test();
  endtask
  task automatic run_mode(input logic [3:0] c, input logic [7:0] h,
      input logic [7:0] l, input int first);
    logic [19:0] e;
    e = exp_period(c[2:0], h, l);
    apb(1'b1, 12'h000, {28'h0, c});
    apb(1'b1, 12'h008, {24'h0, h});
    if (c[3]) begin
      auto_divisor <= {h, l};
      auto_load <= 1'b1;
      @(posedge pclk);
      auto_load <= 1'b0;
      apb(1'b0, 12'h010, 32'h0);
      chk("auto_div", {16'h0, h, l}, rd);
    end else begin
      apb(1'b1, 12'h004, {24'h0, l});
    end
    wait_tick(first == 0 ? int'(e) + 3 : first);
    wait_tick(int'(e) + 3);
    @(posedge pclk);
    chk("period", {12'h0, e}, {12'h0, period});
    chk("mirror", {29'h0, c[2:0]}, {29'h0, wide_divider_select,
      high_speed_select, sync_mode});
    $display("mode %0h done", c);
  endtask
  // ============================================================
  // Main sequence.
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl_reset", 32'h0, rd);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, slv});
    pstrb <= 4'h0;
    apb(1'b1, 12'h000, 32'h7);
    pstrb <= 4'hf;
    apb(1'b0, 12'h000, 32'h0);
    chk("strobe_off", 32'h0, rd);
    for (int c = 0; c < 8; c++) begin
      lo = 8'($random(seed)) & 8'h0f;
      run_mode(4'(c), 8'h01, lo, 0);
    end
    run_mode(4'h6, 8'h00, 8'hff, 0);
    run_mode(4'he, 8'h01, 8'($random(seed)) & 8'h3f, 2400);
    end_of_test();
  end
endmodule // tb_serial_baud_rate_generator
`default_nettype wire
